/* File: dv/latching_interrupt_input_unit_tb.sv */
// Testbench: device and host joined over the link, driven over AHB-Lite
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin mismatches++; \
  $display("ERROR %0t got %h exp %h", $time, (a), (b)); end end
module latching_interrupt_input_unit_tb
  import lii_pkg::*;
;
  logic hclk, hresetn, ce, hsel, hwrite, hreadyout, hresp, irq;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [15:0] in_pin, out_pin, pol, val;
  logic [3:0] slot;
  logic [3:0] seq[$];
  int mismatches, check_count, n_ack, exp_ack;
  lii_link_if link();
  lii_device i_lii_device (.hclk(hclk), .hresetn(hresetn), .ce(ce),
    .in_pin(in_pin), .slot_id(slot), .out_pin(out_pin), .link(link));
  lii_host #(.MS_CYCLES(10)) i_lii_host (.hclk(hclk), .hresetn(hresetn),
    .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .irq(irq),
    .link(link));
  lii_link_properties i_lii_link_properties (.hclk(hclk),
    .hresetn(hresetn), .irq_req(link.irq_req), .irq_chan(link.irq_chan),
    .irq_latch(link.irq_latch), .irq_ack(link.irq_ack),
    .acc_req(link.acc_req), .acc_we(link.acc_we),
    .acc_addr(link.acc_addr), .acc_wdata(link.acc_wdata),
    .acc_ack(link.acc_ack));
  // Count accepted requests and their channel order
  always @(posedge hclk) begin
    if (link.irq_req === 1'b1 && link.irq_ack === 1'b1) begin
      n_ack++;
      seq.push_back(link.irq_chan);
    end
  end
  // Plain channel value seen by the host
  function automatic logic [15:0] exp_in(input logic [15:0] v,
    input logic [15:0] p);
    return v ^ p;
  endfunction
  task automatic ahb(input logic wr, input logic [7:0] a,
    input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  // Busy polling is bounded; a stuck engine shows up as a bad value
  task automatic poll_idle;
    rd = 32'h80000000;
    for (int i = 0; i < 20 && rd[LII_DATA_BUSY] !== 1'b0; i++) begin
      ahb(1'b0, LII_HA_DATA, 32'h00000000);
    end
  endtask
  task automatic acc(input logic we, input logic [3:0] a,
    input logic [15:0] d);
    ahb(1'b1, LII_HA_CMD, {11'h000, we, a, d});
    poll_idle();
  endtask
  task automatic rdc(input logic [3:0] a, input logic [15:0] e);
    acc(1'b0, a, 16'h0000);
    `CHK(rd[15:0], e)
  endtask
  task automatic wait_acks;
    for (int i = 0; i < 80 && n_ack != exp_ack; i++) begin
      @(posedge hclk);
    end
    `CHK(n_ack, exp_ack)
  endtask
  task automatic pulse(input int ch, input int n, input logic lv = 1'b1);
    in_pin[ch] <= lv;
    repeat (n) @(posedge hclk);
    in_pin[ch] <= ~lv;
    repeat (6) @(posedge hclk);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end
  initial begin
    repeat (30000) @(posedge hclk);
    mismatches++;
    tally_and_finish();
  end
  initial begin
    {hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
    ce = 1'b1;
    hsize = 3'h2;
    in_pin = 16'h0000;
    void'($urandom(11));
    slot = 4'($urandom_range(15, 3));
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    rdc(LII_DA_MODE_LO, 16'h0000);
    rdc(LII_DA_EDGE_HI, 16'h5555);
    rdc(LII_DA_HI_CYC, {4'h0, LII_HI_CYC_RST});
    ahb(1'b0, 8'h40, 32'h00000000);
    `CHK({hresp, rd}, 33'h0)
    $display("reset test done");
    repeat (4) begin
      pol = 16'($urandom);
      val = 16'($urandom);
      acc(1'b1, LII_DA_POL, pol);
      in_pin <= val;
      rdc(LII_DA_INPUTS, exp_in(val, pol));
      ahb(1'b1, LII_HA_CTRL, 32'h00000004);
      poll_idle();
      ahb(1'b0, LII_HA_SEG, 32'h00000000);
      `CHK(rd[15:0], exp_in(val, pol))
      acc(1'b1, LII_DA_OUTPUTS, ~val);
      `CHK(out_pin, ~val)
    end
    acc(1'b1, LII_DA_POL, 16'h0000);
    in_pin <= 16'h0000;
    $display("plain input test done");
    ahb(1'b1, LII_HA_MASK, 32'h00000001);
    acc(1'b1, LII_DA_MODE_LO, 16'h0002);
    // Host disabled: request must wait with pending held
    pulse(0, 8);
    rdc(LII_DA_PENDING, 16'h0001);
    `CHK(n_ack, 0)
    ahb(1'b1, LII_HA_CTRL, 32'h00000001);
    exp_ack = 1;
    wait_acks();
    for (int e = 1; e < 4; e++) begin
      acc(1'b1, LII_DA_EDGE_LO, 16'h5554 | 16'(e));
      pulse(0, 8);
      exp_ack += (e == 3) ? 2 : 1;
      wait_acks();
    end
    // Frozen unit must not see a pulse
    ce <= 1'b0;
    pulse(0, 8);
    ce <= 1'b1;
    repeat (8) @(posedge hclk);
    `CHK(n_ack, exp_ack)
    `CHK(irq, 1'b1)
    ahb(1'b0, LII_HA_STATUS, 32'h00000000);
    @(posedge hclk);
    `CHK({irq, rd[0]}, 2'b01)
    $display("edge test done");
    acc(1'b1, LII_DA_MODE_LO, 16'h0400);
    acc(1'b1, LII_DA_HI_CYC, 16'h0008);
    pulse(5, 3);
    rdc(LII_DA_INPUTS, 16'h0000);
    pulse(5, 20);
    rdc(LII_DA_INPUTS, 16'h0020);
    rdc(LII_DA_INPUTS, 16'h0000);
    `CHK(n_ack, exp_ack)
    // Negative logic: low pulse qualified by the low threshold
    in_pin[5] <= 1'b1;
    acc(1'b1, LII_DA_POL, 16'h0020);
    acc(1'b1, LII_DA_LO_CYC, 16'h000C);
    pulse(5, 10, 1'b0);
    rdc(LII_DA_INPUTS, 16'h0000);
    pulse(5, 20, 1'b0);
    rdc(LII_DA_INPUTS, 16'h0020);
    in_pin[5] <= 1'b0;
    acc(1'b1, LII_DA_POL, 16'h0000);
    $display("latch test done");
    in_pin[9] <= 1'b1;
    acc(1'b1, LII_DA_MODE_LO, 16'h0480);
    acc(1'b1, LII_DA_MODE_HI, 16'h0008);
    acc(1'b1, LII_DA_EDGE_HI, 16'h5559);
    pulse(5, 20);
    ahb(1'b0, LII_HA_STATUS, 32'h00000000);
    seq.delete();
    in_pin[3] <= 1'b1;
    in_pin[9] <= 1'b0;
    exp_ack += 2;
    wait_acks();
    `CHK({seq[0], seq[1]}, 8'h39)
    rdc(LII_DA_INPUTS, 16'h0008);
    ahb(1'b0, LII_HA_HANDLER, 32'h00000000);
    `CHK(rd[11:4], {slot, 4'h9})
    ahb(1'b0, LII_HA_STATUS, 32'h00000000);
    `CHK(rd[2:0], 3'h5)
    $display("priority test done");
    ahb(1'b1, LII_HA_CTRL, 32'h00000003);
    ahb(1'b0, LII_HA_HANDLER, 32'h00000000);
    `CHK(rd[1:0], 2'b00)
    ahb(1'b1, LII_HA_TIMER, 32'h00000001);
    repeat (30) @(posedge hclk);
    ahb(1'b1, LII_HA_TIMER, 32'h00000000);
    ahb(1'b0, LII_HA_HANDLER, 32'h00000000);
    `CHK(rd[1:0], 2'b11)
    ahb(1'b0, LII_HA_STATUS, 32'h00000000);
    `CHK(rd[2:0], 3'h6)
    $display("timer test done");
    tally_and_finish();
  end
endmodule
`default_nettype wire

/* File: dv/lii_link_properties.sv */
// Handshake properties on the link between device and host
`timescale 1ns/10ps
`default_nettype none
module lii_link_properties (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic irq_req,
  input wire logic [3:0] irq_chan,
  input wire logic [15:0] irq_latch,
  input wire logic irq_ack,
  input wire logic acc_req,
  input wire logic acc_we,
  input wire logic [3:0] acc_addr,
  input wire logic [15:0] acc_wdata,
  input wire logic acc_ack
);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  property p_req_hold;
    irq_req && !irq_ack |=>
      irq_req && $stable(irq_chan) && $stable(irq_latch);
  endproperty
  a_req_hold: assert property (p_req_hold)
    else $error("request changed before ack");
  property p_ack_end;
    irq_ack |=> !irq_ack && !irq_req;
  endproperty
  a_ack_end: assert property (p_ack_end)
    else $error("ack or request stayed high");
  property p_ack_cause;
    irq_ack |-> irq_req;
  endproperty
  a_ack_cause: assert property (p_ack_cause)
    else $error("ack without request");
  property p_acc_rise;
    $rose(acc_req) |=> acc_ack;
  endproperty
  a_acc_rise: assert property (p_acc_rise)
    else $error("access ack late");
  property p_acc_end;
    acc_ack |=> !acc_ack && !acc_req;
  endproperty
  a_acc_end: assert property (p_acc_end)
    else $error("access ack or request stayed high");
  property p_acc_cause;
    acc_ack |-> acc_req;
  endproperty
  a_acc_cause: assert property (p_acc_cause)
    else $error("access ack without request");
  property p_acc_hold;
    acc_req && !acc_ack |=> acc_req && $stable(acc_addr) &&
      $stable(acc_we) && $stable(acc_wdata);
  endproperty
  a_acc_hold: assert property (p_acc_hold)
    else $error("access request changed before ack");
  property p_req_gap;
    $fell(irq_req) |-> !irq_ack;
  endproperty
  a_req_gap: assert property (p_req_gap)
    else $error("ack after request dropped");
endmodule
`default_nettype wire

/* File: rtl/lii_channel.sv */
// One input channel: synchroniser, edge detect, latch qualifier
`timescale 1ns/10ps
`default_nettype none
module lii_channel
  import lii_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic pin,
  input wire logic [1:0] mode,
  input wire logic [1:0] edge_sel,
  input wire logic pol,
  input wire logic [11:0] hi_cyc,
  input wire logic [11:0] lo_cyc,
  input wire logic pend_clr,
  input wire logic latch_clr,
  output logic level,
  output logic latched,
  output logic pending
);
  logic sync1, sync2, prev;
  logic [11:0] cnt;
  logic next_prev, next_latched, next_pending;
  logic [11:0] next_cnt, thr;
  logic rise, fall, hit;

  always_comb begin
    level = sync2 ^ pol; // R1
    // Active high voltage needs hi_cyc, active low voltage lo_cyc
    thr = sync2 ? hi_cyc : lo_cyc; // R12 R17
    rise = level & ~prev;
    fall = ~level & prev;
    hit = level && ((cnt + 12'h001) >= thr);
    next_prev = level;
    next_cnt = level ? (hit ? cnt : cnt + 12'h001) : 12'h000;
    // Set wins over a clear in the same cycle
    next_latched = (mode == LII_MODE_LATCH) &&
      (hit || (latched && !latch_clr)); // R9
    next_pending = (mode == LII_MODE_IRQ) && // R10
      ((rise && edge_sel[0]) || (fall && edge_sel[1]) || // R4
      (pending && !pend_clr)); // R16
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
      prev <= 1'b0;
      cnt <= 12'h000;
      latched <= 1'b0;
      pending <= 1'b0;
    end else if (ce) begin
      sync1 <= pin; // R16
      sync2 <= sync1;
      prev <= next_prev;
      cnt <= next_cnt;
      latched <= next_latched;
      pending <= next_pending;
    end
  end
endmodule
`default_nettype wire

/* File: rtl/lii_device.sv */
// Sixteen-channel input unit: channels, config registers, request logic
`timescale 1ns/10ps
`default_nettype none
module lii_device
  import lii_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic [15:0] in_pin,
  input wire logic [3:0] slot_id,
  output logic [15:0] out_pin,
  lii_link_if.dev link
);
  typedef enum logic {LII_DEV_IDLE, LII_DEV_REQ} lii_dev_state_type;

  lii_dev_state_type state, next_state;
  logic [31:0] mode_bits, next_mode_bits;
  logic [31:0] edge_bits, next_edge_bits;
  logic [15:0] pol, next_pol;
  logic [11:0] hi_cyc, next_hi_cyc;
  logic [11:0] lo_cyc, next_lo_cyc;
  logic [15:0] outputs, next_outputs;
  logic [3:0] slot_s1, slot_s2;
  logic irq_req, next_irq_req;
  logic [3:0] irq_chan, next_irq_chan;
  logic [15:0] irq_latch, next_irq_latch;
  logic acc_ack, next_acc_ack;
  logic [15:0] acc_rdata, next_acc_rdata;
  logic [15:0] level, latched, pending, latch_mask;
  logic [15:0] pend_clr, rd_clr, ack_clr, rd_val, inputs_val;

  // Lowest index wins
  function automatic logic [3:0] lowest_set(input logic [15:0] v);
    logic [3:0] idx;
    idx = 4'h0;
    for (int i = LII_CHANNELS - 1; i >= 0; i--) begin
      if (v[i]) begin
        idx = 4'(i);
      end
    end
    return idx;
  endfunction

  for (genvar i = 0; i < LII_CHANNELS; i++) begin : g_ch
    assign latch_mask[i] = mode_bits[2*i +: 2] == LII_MODE_LATCH;
    lii_channel u_ch (
      .hclk(hclk),
      .hresetn(hresetn),
      .ce(ce),
      .pin(in_pin[i]),
      .mode(mode_bits[2*i +: 2]), // R2
      .edge_sel(edge_bits[2*i +: 2]),
      .pol(pol[i]),
      .hi_cyc(hi_cyc),
      .lo_cyc(lo_cyc),
      .pend_clr(pend_clr[i]),
      .latch_clr(rd_clr[i] | ack_clr[i]),
      .level(level[i]),
      .latched(latched[i]),
      .pending(pending[i])
    );
  end

  // Latch channels report the held value, others the live level
  assign inputs_val = (latched & latch_mask) | (level & ~latch_mask);

  always_comb begin
    unique case (link.acc_addr)
      LII_DA_INPUTS: rd_val = inputs_val;
      LII_DA_MODE_LO: rd_val = mode_bits[15:0];
      LII_DA_MODE_HI: rd_val = mode_bits[31:16];
      LII_DA_EDGE_LO: rd_val = edge_bits[15:0];
      LII_DA_EDGE_HI: rd_val = edge_bits[31:16];
      LII_DA_POL: rd_val = pol;
      LII_DA_HI_CYC: rd_val = {4'h0, hi_cyc};
      LII_DA_LO_CYC: rd_val = {4'h0, lo_cyc};
      LII_DA_PENDING: rd_val = pending;
      LII_DA_OUTPUTS: rd_val = outputs;
      default: rd_val = 16'h0000;
    endcase
  end

  // Immediate access path, answered one cycle after the request
  always_comb begin
    next_mode_bits = mode_bits;
    next_edge_bits = edge_bits;
    next_pol = pol;
    next_hi_cyc = hi_cyc;
    next_lo_cyc = lo_cyc;
    next_outputs = outputs;
    next_acc_ack = 1'b0;
    next_acc_rdata = acc_rdata;
    rd_clr = 16'h0000;
    // Ack high blocks a second answer to the same held request
    if (link.acc_req && !acc_ack) begin // R14
      next_acc_ack = 1'b1;
      if (link.acc_we) begin
        unique case (link.acc_addr)
          LII_DA_MODE_LO: next_mode_bits[15:0] = link.acc_wdata;
          LII_DA_MODE_HI: next_mode_bits[31:16] = link.acc_wdata;
          LII_DA_EDGE_LO: next_edge_bits[15:0] = link.acc_wdata;
          LII_DA_EDGE_HI: next_edge_bits[31:16] = link.acc_wdata;
          LII_DA_POL: next_pol = link.acc_wdata; // R1
          LII_DA_HI_CYC: next_hi_cyc = link.acc_wdata[11:0]; // R17
          LII_DA_LO_CYC: next_lo_cyc = link.acc_wdata[11:0]; // R17
          LII_DA_OUTPUTS: next_outputs = link.acc_wdata; // R14
          default: ;
        endcase
      end else begin
        next_acc_rdata = rd_val;
        if (link.acc_addr == LII_DA_INPUTS) begin
          rd_clr = latched & latch_mask; // R9
        end
      end
    end
  end

  // Interrupt presentation and handshake
  always_comb begin
    next_state = state;
    next_irq_req = irq_req;
    next_irq_chan = irq_chan;
    next_irq_latch = irq_latch;
    pend_clr = 16'h0000;
    ack_clr = 16'h0000;
    unique case (state)
      LII_DEV_IDLE: begin
        if (|pending) begin
          next_irq_req = 1'b1; // R8
          next_irq_chan = lowest_set(pending); // R5
          next_irq_latch = latched & latch_mask; // R11
          next_state = LII_DEV_REQ;
        end
      end
      LII_DEV_REQ: begin
        // Request held until acknowledged, then one idle cycle
        if (link.irq_ack) begin // R8
          next_irq_req = 1'b0;
          pend_clr = 16'h0001 << irq_chan; // R16
          // Only values actually returned are cleared
          ack_clr = irq_latch; // R11
          next_state = LII_DEV_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= LII_DEV_IDLE;
      mode_bits <= LII_MODE_RST; // R3
      edge_bits <= LII_EDGE_RST;
      pol <= LII_POL_RST;
      hi_cyc <= LII_HI_CYC_RST; // R12
      lo_cyc <= LII_LO_CYC_RST; // R12
      outputs <= 16'h0000;
      out_pin <= 16'h0000;
      slot_s1 <= 4'h0;
      slot_s2 <= 4'h0;
      irq_req <= 1'b0;
      irq_chan <= 4'h0;
      irq_latch <= 16'h0000;
      acc_ack <= 1'b0;
      acc_rdata <= 16'h0000;
    end else if (ce) begin
      state <= next_state;
      mode_bits <= next_mode_bits;
      edge_bits <= next_edge_bits;
      pol <= next_pol;
      hi_cyc <= next_hi_cyc;
      lo_cyc <= next_lo_cyc;
      outputs <= next_outputs;
      out_pin <= next_outputs;
      slot_s1 <= slot_id;
      slot_s2 <= slot_s1;
      irq_req <= next_irq_req;
      irq_chan <= next_irq_chan;
      irq_latch <= next_irq_latch;
      acc_ack <= next_acc_ack;
      acc_rdata <= next_acc_rdata;
    end
  end

  assign link.irq_req = irq_req;
  assign link.irq_chan = irq_chan;
  assign link.irq_slot = slot_s2; // R6
  assign link.irq_latch = irq_latch;
  assign link.acc_ack = acc_ack;
  assign link.acc_rdata = acc_rdata;
endmodule
`default_nettype wire

/* File: rtl/lii_host.sv */
// Host end: AHB-Lite registers, handler tracking, timer, access engine
//
// The AHB-Lite interface to the registers and the address map were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module lii_host
  import lii_pkg::*;
#(
  parameter int MS_CYCLES = LII_MS_CYCLES
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output logic irq,
  lii_link_if.host link
);
  logic en, active, src_timer, timer_pend, irq_ack;
  logic acc_busy, acc_refresh, acc_req, acc_we, wr_pend;
  logic [3:0] h_chan, h_slot, acc_addr;
  logic [15:0] h_latch, timer_ms, ms_cnt, presc, acc_wdata;
  logic [15:0] acc_data, seg_inputs;
  logic [7:0] wr_addr;
  logic [LII_ST_W-1:0] status, mask;
  logic next_en, next_active, next_src_timer, next_timer_pend;
  logic next_irq_ack, next_acc_busy, next_acc_refresh, next_acc_req;
  logic next_acc_we, next_wr_pend, next_irq;
  logic [3:0] next_h_chan, next_h_slot, next_acc_addr;
  logic [15:0] next_h_latch, next_timer_ms, next_ms_cnt, next_presc;
  logic [15:0] next_acc_wdata, next_acc_data, next_seg_inputs;
  logic [7:0] next_wr_addr;
  logic [LII_ST_W-1:0] next_status, next_mask, ev, st_clr;
  logic [31:0] next_hrdata, rd_val;
  logic done, refresh_req, cmd_req, tick, timer_fire;

  always_comb begin
    unique case (haddr[7:0])
      LII_HA_CTRL: rd_val = {31'h0, en};
      LII_HA_TIMER: rd_val = {16'h0, timer_ms};
      LII_HA_DATA: rd_val = {acc_busy, 15'h0, acc_data};
      LII_HA_SEG: rd_val = {16'h0, seg_inputs};
      LII_HA_HANDLER: rd_val = {h_latch, 4'h0, h_slot, h_chan,
        2'h0, src_timer, active};
      LII_HA_STATUS: rd_val = {27'h0, status};
      LII_HA_MASK: rd_val = {27'h0, mask};
      default: rd_val = 32'h00000000;
    endcase
  end

  always_comb begin
    next_en = en;
    next_timer_ms = timer_ms;
    next_mask = mask;
    done = 1'b0;
    refresh_req = 1'b0;
    cmd_req = 1'b0;
    if (wr_pend) begin
      unique case (wr_addr)
        LII_HA_CTRL: begin
          next_en = hwdata[LII_CTRL_EN];
          done = hwdata[LII_CTRL_DONE];
          refresh_req = hwdata[LII_CTRL_REFRESH];
        end
        LII_HA_TIMER: next_timer_ms = hwdata[15:0];
        LII_HA_CMD: cmd_req = 1'b1;
        LII_HA_MASK: next_mask = hwdata[LII_ST_W-1:0];
        default: ;
      endcase
    end
    // Interval in whole milliseconds, zero stops the timer
    tick = (timer_ms != 16'h0000) && (presc == 16'(MS_CYCLES - 1));
    next_presc = (timer_ms == 16'h0000 || tick) ? 16'h0000
      : presc + 16'h0001;
    next_ms_cnt = (timer_ms == 16'h0000) ? 16'h0000 : ms_cnt;
    timer_fire = 1'b0;
    if (tick) begin // R15
      if ((ms_cnt + 16'h0001) >= timer_ms) begin
        next_ms_cnt = 16'h0000;
        timer_fire = 1'b1;
      end else begin
        next_ms_cnt = ms_cnt + 16'h0001;
      end
    end
    ev = '0;
    next_irq_ack = 1'b0;
    next_active = done ? 1'b0 : active;
    next_src_timer = src_timer;
    next_h_chan = h_chan;
    next_h_slot = h_slot;
    next_h_latch = h_latch;
    next_timer_pend = timer_fire | timer_pend;
    // Unit requests rank above the timer; a take wins over done
    if (en && link.irq_req && !irq_ack) begin // R8
      next_irq_ack = 1'b1;
      next_active = 1'b1;
      next_src_timer = 1'b0;
      next_h_chan = link.irq_chan;
      next_h_slot = link.irq_slot; // R6
      next_h_latch = link.irq_latch;
      ev[LII_ST_UNIT] = 1'b1;
      ev[LII_ST_PREEMPT] = active; // R7
    end else if (en && timer_pend) begin // R15
      next_timer_pend = timer_fire;
      next_active = 1'b1;
      next_src_timer = 1'b1;
      ev[LII_ST_TIMER] = 1'b1;
      ev[LII_ST_PREEMPT] = active; // R7
    end
    next_acc_busy = acc_busy;
    next_acc_refresh = acc_refresh;
    next_acc_req = acc_req;
    next_acc_we = acc_we;
    next_acc_addr = acc_addr;
    next_acc_wdata = acc_wdata;
    next_acc_data = acc_data;
    next_seg_inputs = seg_inputs;
    // Commands arriving while busy are dropped
    if (acc_busy) begin
      if (link.acc_ack) begin
        next_acc_req = 1'b0;
        next_acc_busy = 1'b0;
        if (acc_refresh) begin
          next_seg_inputs = link.acc_rdata; // R13
          ev[LII_ST_REFRESH] = 1'b1;
        end else begin
          next_acc_data = link.acc_rdata;
          ev[LII_ST_ACC] = 1'b1;
        end
      end
    end else if (cmd_req) begin // R14
      next_acc_busy = 1'b1;
      next_acc_req = 1'b1;
      next_acc_refresh = 1'b0;
      next_acc_we = hwdata[LII_CMD_WE];
      next_acc_addr = hwdata[LII_CMD_ADDR_LSB +: 4];
      next_acc_wdata = hwdata[15:0];
    end else if (refresh_req) begin // R13
      next_acc_busy = 1'b1;
      next_acc_req = 1'b1;
      next_acc_refresh = 1'b1;
      next_acc_we = 1'b0;
      next_acc_addr = LII_DA_INPUTS;
    end
    next_wr_pend = 1'b0;
    next_wr_addr = wr_addr;
    next_hrdata = hrdata;
    st_clr = '0;
    if (hsel && htrans[1] && hready) begin
      if (hwrite) begin
        next_wr_pend = 1'b1;
        next_wr_addr = haddr[7:0];
      end else begin
        next_hrdata = rd_val;
        if (haddr[7:0] == LII_HA_STATUS) begin
          st_clr = status;
        end
      end
    end
    next_status = (status & ~st_clr) | ev;
    next_irq = |(next_status & next_mask);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      en <= 1'b0;
      active <= 1'b0;
      src_timer <= 1'b0;
      timer_pend <= 1'b0;
      irq_ack <= 1'b0;
      h_chan <= 4'h0;
      h_slot <= 4'h0;
      h_latch <= 16'h0000;
      timer_ms <= 16'h0000;
      ms_cnt <= 16'h0000;
      presc <= 16'h0000;
      acc_busy <= 1'b0;
      acc_refresh <= 1'b0;
      acc_req <= 1'b0;
      acc_we <= 1'b0;
      acc_addr <= 4'h0;
      acc_wdata <= 16'h0000;
      acc_data <= 16'h0000;
      seg_inputs <= 16'h0000;
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
      status <= '0;
      mask <= '0;
      hrdata <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      irq <= 1'b0;
    end else if (ce) begin
      en <= next_en;
      active <= next_active;
      src_timer <= next_src_timer;
      timer_pend <= next_timer_pend;
      irq_ack <= next_irq_ack;
      h_chan <= next_h_chan;
      h_slot <= next_h_slot;
      h_latch <= next_h_latch;
      timer_ms <= next_timer_ms;
      ms_cnt <= next_ms_cnt;
      presc <= next_presc;
      acc_busy <= next_acc_busy;
      acc_refresh <= next_acc_refresh;
      acc_req <= next_acc_req;
      acc_we <= next_acc_we;
      acc_addr <= next_acc_addr;
      acc_wdata <= next_acc_wdata;
      acc_data <= next_acc_data;
      seg_inputs <= next_seg_inputs;
      wr_pend <= next_wr_pend;
      wr_addr <= next_wr_addr;
      status <= next_status;
      mask <= next_mask;
      hrdata <= next_hrdata;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      irq <= next_irq;
    end
  end

  assign link.irq_ack = irq_ack;
  assign link.acc_req = acc_req;
  assign link.acc_we = acc_we;
  assign link.acc_addr = acc_addr;
  assign link.acc_wdata = acc_wdata;
endmodule
`default_nettype wire

/* File: rtl/lii_link_if.sv */
// Link between the input unit and the host
`timescale 1ns/10ps
`default_nettype none
interface lii_link_if;
  logic irq_req;
  logic [3:0] irq_chan;
  logic [3:0] irq_slot;
  logic [15:0] irq_latch;
  logic irq_ack;
  logic acc_req;
  logic acc_we;
  logic [3:0] acc_addr;
  logic [15:0] acc_wdata;
  logic acc_ack;
  logic [15:0] acc_rdata;
  modport dev (
    output irq_req, irq_chan, irq_slot, irq_latch, acc_ack, acc_rdata,
    input irq_ack, acc_req, acc_we, acc_addr, acc_wdata
  );
  modport host (
    input irq_req, irq_chan, irq_slot, irq_latch, acc_ack, acc_rdata,
    output irq_ack, acc_req, acc_we, acc_addr, acc_wdata
  );
endinterface
`default_nettype wire

/* File: rtl/lii_pkg.sv */
// Shared constants and rule summary for the latching interrupt input unit
// What this block does
// R1: Sixteen inputs, each with programmable polarity
// R2: Per-channel mode: interrupt, latch or plain
// R3: Plain high-speed input is the reset mode
// R4: Interrupt on rise, fall or either edge
// R5: Lowest-numbered pending channel is presented first
// R6: Lowest slot wins among simultaneous units; the host only records the slot of its single unit
// R7: Host pre-empts running handler for new request
// R8: Request and acknowledge handshake loses nothing
// R9: Latch holds pulse, clears when host reads
// R10: Latch-mode channels never raise interrupts
// R11: Serviced interrupt returns and clears latched values
// R12: Latch needs 30 us high, 130 us low
// R13: Host samples plain inputs at segment end
// R14: Immediate access path reads inputs, writes outputs
// R15: Host periodic timer interrupt, 1 ms minimum
// R16: Two-flop synchroniser; pending held until acknowledged
// R17: Latch qualification is a programmable cycle count
package lii_pkg;
  localparam int LII_CHANNELS = 16;
  localparam int LII_CLK_PERIOD_NS = 40;
  localparam int LII_HI_PULSE_NS = 30000;
  localparam int LII_LO_PULSE_NS = 130000;
  localparam int LII_MS_NS = 1000000;
  localparam logic [11:0] LII_HI_CYC_RST =
    12'((LII_HI_PULSE_NS + LII_CLK_PERIOD_NS - 1) / LII_CLK_PERIOD_NS);
  localparam logic [11:0] LII_LO_CYC_RST =
    12'((LII_LO_PULSE_NS + LII_CLK_PERIOD_NS - 1) / LII_CLK_PERIOD_NS);
  localparam int LII_MS_CYCLES = LII_MS_NS / LII_CLK_PERIOD_NS;
  // Channel modes and edge selections
  localparam logic [1:0] LII_MODE_PLAIN = 2'h0;
  localparam logic [1:0] LII_MODE_LATCH = 2'h1;
  localparam logic [1:0] LII_MODE_IRQ = 2'h2;
  localparam logic [1:0] LII_EDGE_RISE = 2'h1;
  localparam logic [1:0] LII_EDGE_FALL = 2'h2;
  localparam logic [31:0] LII_MODE_RST = 32'h00000000;
  localparam logic [31:0] LII_EDGE_RST = 32'h55555555;
  localparam logic [15:0] LII_POL_RST = 16'h0000;
  // Device registers on the link
  localparam logic [3:0] LII_DA_INPUTS = 4'h0;
  localparam logic [3:0] LII_DA_MODE_LO = 4'h1;
  localparam logic [3:0] LII_DA_MODE_HI = 4'h2;
  localparam logic [3:0] LII_DA_EDGE_LO = 4'h3;
  localparam logic [3:0] LII_DA_EDGE_HI = 4'h4;
  localparam logic [3:0] LII_DA_POL = 4'h5;
  localparam logic [3:0] LII_DA_HI_CYC = 4'h6;
  localparam logic [3:0] LII_DA_LO_CYC = 4'h7;
  localparam logic [3:0] LII_DA_PENDING = 4'h8;
  localparam logic [3:0] LII_DA_OUTPUTS = 4'h9;
  // Host registers on AHB-Lite
  localparam logic [7:0] LII_HA_CTRL = 8'h00;
  localparam logic [7:0] LII_HA_TIMER = 8'h04;
  localparam logic [7:0] LII_HA_CMD = 8'h08;
  localparam logic [7:0] LII_HA_DATA = 8'h0C;
  localparam logic [7:0] LII_HA_SEG = 8'h10;
  localparam logic [7:0] LII_HA_HANDLER = 8'h14;
  localparam logic [7:0] LII_HA_STATUS = 8'h18;
  localparam logic [7:0] LII_HA_MASK = 8'h1C;
  localparam int LII_CTRL_EN = 0;
  localparam int LII_CTRL_DONE = 1;
  localparam int LII_CTRL_REFRESH = 2;
  localparam int LII_CMD_ADDR_LSB = 16;
  localparam int LII_CMD_WE = 20;
  localparam int LII_DATA_BUSY = 31;
  localparam int LII_ST_UNIT = 0;
  localparam int LII_ST_TIMER = 1;
  localparam int LII_ST_PREEMPT = 2;
  localparam int LII_ST_ACC = 3;
  localparam int LII_ST_REFRESH = 4;
  localparam int LII_ST_W = 5;
endpackage
